// [design/pps_regs.v]
// What this block does
// R1: 3-bit page index picks which page answers addresses 8 to 15; reset 0.
// R2: 4-bit port index picks the port for per-port fields; reset 0.
// R3: software writes page 0 and port number into register 7 first.
// R4: unimplemented port selected: whole port status page reads zero.
// R5: line A state field: 11 Z, 01 one, 10 zero, 00 invalid.
// R6: line B state field uses the same four codes as line A.
// R7: child flag 1 for child, 0 parent; disconnected/disabled/suspended read child.
// R8: software ignores child flag from bus-reset until tree identification ends.
// R9: attached flag sets only after connection stable about 341 ms.
// R10: bias flag sets only after incoming bias stable for 52 us.
// R11: writable port-off bit disables the port; reset 0 so all enabled.
// R12: neighbour-rate field reports peer speed: 000 S100, 001 S200, 010 S400.
// R13: software ignores neighbour rate from bus-reset until self-identification ends.
// R14: with port irq enable set, port events set the event flag and notify link.
// R15: fault flag sets on resume or suspend failure; port held suspended.
// R16: resume failure: resuming port sees no incoming bias.
// R17: suspend failure: suspending port still sees incoming bias.
// R18: writing 1 clears the fault flag, writing 0 does nothing.
// R19: page index 1 maps the identification page onto addresses 8 to 15.
// R20: event flag sets on attached, bias, disabled or fault change; write 1 clears.
// R21: reserved bits and addresses read zero and ignore writes.
// R22: each access uses the port index held at that moment.
`timescale 1ns/1ps
`default_nettype none

`include "pps_consts.vh"

module pps_regs #(
	parameter CON_DEB_CYC  = `PPS_CON_DEB_MS * 1000 * `PPS_CLK_MHZ,
	parameter BIAS_DEB_CYC = `PPS_BIAS_DEB_US * `PPS_CLK_MHZ
) (
	input  wire                       core_clk_i,
	input  wire                       rst_n_i,
	// axi4-lite slave
	input  wire [31:0]                s_axi_awaddr,
	input  wire                       s_axi_awvalid,
	output reg                        s_axi_awready,
	input  wire [31:0]                s_axi_wdata,
	input  wire [3:0]                 s_axi_wstrb,
	input  wire                       s_axi_wvalid,
	output reg                        s_axi_wready,
	output reg  [1:0]                 s_axi_bresp,
	output reg                        s_axi_bvalid,
	input  wire                       s_axi_bready,
	input  wire [31:0]                s_axi_araddr,
	input  wire                       s_axi_arvalid,
	output reg                        s_axi_arready,
	output reg  [31:0]                s_axi_rdata,
	output reg  [1:0]                 s_axi_rresp,
	output reg                        s_axi_rvalid,
	input  wire                       s_axi_rready,
	// per-port pins, asynchronous
	input  wire [2*`PPS_NPORTS-1:0]   cable_pair_a_state_i,
	input  wire [2*`PPS_NPORTS-1:0]   cable_pair_b_state_i,
	input  wire [`PPS_NPORTS-1:0]     port_connect_raw_i,
	input  wire [`PPS_NPORTS-1:0]     port_bias_raw_i,
	// per-port status from the port state logic, same clock
	input  wire [`PPS_NPORTS-1:0]     port_is_child_i,
	input  wire [`PPS_NPORTS-1:0]     port_suspended_i,
	input  wire [3*`PPS_NPORTS-1:0]   peer_speed_i,
	input  wire [`PPS_NPORTS-1:0]     resume_check_i,
	input  wire [`PPS_NPORTS-1:0]     suspend_check_i,
	// controls back to the ports and the link
	output reg  [`PPS_NPORTS-1:0]     port_disable_o,
	output reg  [`PPS_NPORTS-1:0]     port_hold_suspend_o,
	output reg                        link_notify_o
);

	localparam NP = `PPS_NPORTS;
	localparam [23:0] VID = `PPS_VENDOR_ID;
	localparam [23:0] PID = `PPS_PRODUCT_ID;

	// index decode shared by the read and the write path
	function addr_ok;
		input [31:0] a;
		begin
			addr_ok = (a[`PPS_A_HIGH] == `PPS_A_HIGH_ZERO) &&
				((a[`PPS_A_IDX] == `PPS_IDX_EVT) ||
				 (a[`PPS_A_IDX] == `PPS_IDX_BASE) ||
				 (a[`PPS_A_IDX] >= `PPS_IDX_PAGED_LO));
		end
	endfunction

	reg [2:0]             page_sel_r;
	reg [`PPS_PSEL_W-1:0] port_sel_r;
	reg [NP-1:0]          dis_r;
	reg [NP-1:0]          pie_r;
	reg [NP-1:0]          fault_r;
	reg [NP-1:0]          con_q_r;
	reg [NP-1:0]          bias_q_r;
	reg [NP-1:0]          dis_q_r;
	reg [NP-1:0]          fault_q_r;
	reg                   evt_flag_r;

	wire [2*NP-1:0] line_a_state;
	wire [2*NP-1:0] line_b_state;
	wire [NP-1:0]   con_sync;
	wire [NP-1:0]   bias_sync;
	wire [NP-1:0]   con_db;
	wire [NP-1:0]   bias_db;
	wire [NP-1:0]   fault_set;
	wire [NP-1:0]   port_chg;

	pps_sync3 #(
		.W(6*NP)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i   (rst_n_i),
		.async_i   ({cable_pair_a_state_i, cable_pair_b_state_i,
		             port_connect_raw_i, port_bias_raw_i}),
		.sync_o    ({line_a_state, line_b_state, con_sync, bias_sync})
	);

	genvar p;
	generate
		for (p = 0; p < NP; p = p + 1)
		begin : g_port
			pps_debounce #(
				.CYC(CON_DEB_CYC)
			) u_con_deb (
				.core_clk_i(core_clk_i),
				.rst_n_i   (rst_n_i),
				.level_i   (con_sync[p]),
				.stable_o  (con_db[p])
			); // R9
			pps_debounce #(
				.CYC(BIAS_DEB_CYC)
			) u_bias_deb (
				.core_clk_i(core_clk_i),
				.rst_n_i   (rst_n_i),
				.level_i   (bias_sync[p]),
				.stable_o  (bias_db[p])
			); // R10
			assign fault_set[p] = (resume_check_i[p] & ~bias_db[p]) | // R16
				(suspend_check_i[p] & bias_db[p]); // R17
			assign port_chg[p] = (con_db[p] ^ con_q_r[p]) |
				(bias_db[p] ^ bias_q_r[p]) |
				(dis_r[p] ^ dis_q_r[p]) |
				(fault_r[p] ^ fault_q_r[p]); // R20
		end
	endgenerate

	// write channel: address and data may arrive in either order
	reg        aw_held_r;
	reg        w_held_r;
	reg [31:0] aw_addr_r;
	reg [7:0]  w_byte_r;
	reg        w_lane0_r;

	wire       wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
	wire       wr_ok   = addr_ok(aw_addr_r);
	wire [3:0] wr_idx  = aw_addr_r[`PPS_A_IDX];
	wire       wr_en   = wr_fire && wr_ok && w_lane0_r;
	wire       port_ok = (port_sel_r < NP);
	wire       wr_port = wr_en && (page_sel_r == `PPS_PAGE_PORT) && port_ok; // R4

	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			aw_held_r     <= 1'b0;
			w_held_r      <= 1'b0;
			aw_addr_r     <= 32'h0;
			w_byte_r      <= 8'h0;
			w_lane0_r     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PPS_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r  <= 1'b1;
				w_byte_r  <= s_axi_wdata[7:0];
				w_lane0_r <= s_axi_wstrb[`PPS_BYTE0];
			end
			if (wr_fire)
			begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// index register: no bus-reset input, so only hardware reset clears it
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			page_sel_r <= `PPS_PAGE_PORT; // R1
			port_sel_r <= {`PPS_PSEL_W{1'b0}}; // R2
		end
		else if (wr_en && wr_idx == `PPS_IDX_BASE)
		begin
			page_sel_r <= w_byte_r[`PPS_F_PAGE]; // R1
			port_sel_r <= w_byte_r[`PPS_F_PORT]; // R2
		end
	end

	// per-port storage; only the selected port's bits move on a write
	integer k;
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dis_r     <= {NP{1'b0}};
			pie_r     <= {NP{1'b0}};
			fault_r   <= {NP{1'b0}};
			con_q_r   <= {NP{1'b0}};
			bias_q_r  <= {NP{1'b0}};
			dis_q_r   <= {NP{1'b0}};
			fault_q_r <= {NP{1'b0}};
		end
		else
		begin
			con_q_r   <= con_db;
			bias_q_r  <= bias_db;
			dis_q_r   <= dis_r;
			fault_q_r <= fault_r;
			for (k = 0; k < NP; k = k + 1)
			begin
				if (wr_port && port_sel_r == k && wr_idx == `PPS_IDX_R8)
					dis_r[k] <= w_byte_r[`PPS_F_DIS]; // R11
				if (wr_port && port_sel_r == k && wr_idx == `PPS_IDX_R9)
					pie_r[k] <= w_byte_r[`PPS_F_PIE]; // R14
				// a new failure in the clearing cycle wins
				if (fault_set[k])
					fault_r[k] <= 1'b1; // R15
				else if (wr_port && port_sel_r == k && wr_idx == `PPS_IDX_R9 &&
					w_byte_r[`PPS_F_FAULT])
					fault_r[k] <= 1'b0; // R18
			end
		end
	end

	// event flag, one for all ports
	wire evt_set = |(port_chg & pie_r); // R14 R20
	wire evt_clr = wr_en && wr_idx == `PPS_IDX_EVT && w_byte_r[`PPS_F_EVT];

	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			evt_flag_r          <= 1'b0;
			link_notify_o       <= 1'b0;
			port_disable_o      <= {NP{1'b0}};
			port_hold_suspend_o <= {NP{1'b0}};
		end
		else
		begin
			evt_flag_r          <= evt_set | (evt_flag_r & ~evt_clr); // R20
			link_notify_o       <= evt_set | (evt_flag_r & ~evt_clr); // R14
			port_disable_o      <= dis_r; // R11
			port_hold_suspend_o <= fault_r | fault_set; // R15
		end
	end

	// read data for the selected port
	reg [7:0] rd_byte;
	reg [7:0] r8_byte;
	reg [7:0] r9_byte;
	reg [2:0] sel_spd;
	integer   j;

	always @*
	begin
		r8_byte = 8'h0;
		r9_byte = 8'h0;
		sel_spd = `PPS_SPD_S100;
		for (j = 0; j < NP; j = j + 1)
		begin
			if (port_sel_r == j) // R22
			begin
				r8_byte[`PPS_F_LINE_A_STATE] = line_a_state[2*j +: 2]; // R5
				r8_byte[`PPS_F_BSTAT] = line_b_state[2*j +: 2]; // R6
				r8_byte[`PPS_F_CHILD] = port_is_child_i[j] | ~con_db[j] | dis_r[j] |
					port_suspended_i[j] | fault_r[j]; // R7
				r8_byte[`PPS_F_CON]   = con_db[j]; // R9
				r8_byte[`PPS_F_BIAS]  = bias_db[j]; // R10
				r8_byte[`PPS_F_DIS]   = dis_r[j]; // R11
				sel_spd               = peer_speed_i[3*j +: 3];
				r9_byte[`PPS_F_PIE]   = pie_r[j]; // R14
				r9_byte[`PPS_F_FAULT] = fault_r[j]; // R15
			end
		end
		// codes above S400 are passed on; software treats them as invalid
		r9_byte[`PPS_F_SPEED] = sel_spd; // R12
	end

	always @*
	begin
		rd_byte = 8'h0; // R21
		case (s_axi_araddr[`PPS_A_IDX])
			`PPS_IDX_EVT:
				rd_byte[`PPS_F_EVT] = evt_flag_r;
			`PPS_IDX_BASE:
			begin
				rd_byte[`PPS_F_PAGE] = page_sel_r;
				rd_byte[`PPS_F_PORT] = port_sel_r;
			end
			`PPS_IDX_R8:
				if (page_sel_r == `PPS_PAGE_PORT && port_ok)
					rd_byte = r8_byte; // R4
				else if (page_sel_r == `PPS_PAGE_ID)
					rd_byte = `PPS_COMPLIANCE; // R19
			`PPS_IDX_R9:
				if (page_sel_r == `PPS_PAGE_PORT && port_ok)
					rd_byte = r9_byte; // R4
			`PPS_IDX_RA:
				if (page_sel_r == `PPS_PAGE_ID)
					rd_byte = VID[23:16]; // R19
			`PPS_IDX_RB:
				if (page_sel_r == `PPS_PAGE_ID)
					rd_byte = VID[15:8];
			`PPS_IDX_RC:
				if (page_sel_r == `PPS_PAGE_ID)
					rd_byte = VID[7:0];
			`PPS_IDX_RD:
				if (page_sel_r == `PPS_PAGE_ID)
					rd_byte = PID[23:16];
			`PPS_IDX_RE:
				if (page_sel_r == `PPS_PAGE_ID)
					rd_byte = PID[15:8];
			`PPS_IDX_RF:
				if (page_sel_r == `PPS_PAGE_ID)
					rd_byte = PID[7:0];
			default:
				rd_byte = 8'h0;
		endcase
	end

	// read channel: one outstanding read, answered the cycle after capture
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `PPS_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= addr_ok(s_axi_araddr) ? {24'h0, rd_byte} : 32'h0; // R21
				s_axi_rresp  <= addr_ok(s_axi_araddr) ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule // pps_regs
`default_nettype wire

// [design/pps_consts.vh]
`ifndef PPS_CONSTS_VH
`define PPS_CONSTS_VH

// implemented ports; the 4-bit index can name up to sixteen
`define PPS_NPORTS        8
`define PPS_PSEL_W        4

// register indexes; byte address is four times the index
`define PPS_IDX_EVT       4'h5
`define PPS_IDX_BASE      4'h7
`define PPS_IDX_PAGED_LO  4'h8
`define PPS_IDX_R8        4'h8
`define PPS_IDX_R9        4'h9
`define PPS_IDX_RA        4'ha
`define PPS_IDX_RB        4'hb
`define PPS_IDX_RC        4'hc
`define PPS_IDX_RD        4'hd
`define PPS_IDX_RE        4'he
`define PPS_IDX_RF        4'hf

// address layout on the bus
`define PPS_A_IDX         5:2
`define PPS_A_HIGH        31:6
`define PPS_A_HIGH_ZERO   26'h0

// base register 7 fields
`define PPS_F_PAGE        7:5
`define PPS_F_PORT        3:0
`define PPS_PAGE_PORT     3'h0
`define PPS_PAGE_ID       3'h1

// port status page, register 8
`define PPS_F_LINE_A_STATE       7:6
`define PPS_F_BSTAT       5:4
`define PPS_F_CHILD       3
`define PPS_F_CON         2
`define PPS_F_BIAS        1
`define PPS_F_DIS         0
// port status page, register 9
`define PPS_F_SPEED       7:5
`define PPS_F_PIE         4
`define PPS_F_FAULT       3
// own event register
`define PPS_F_EVT         0

// line state and speed codes
`define PPS_LINE_Z        2'h3
`define PPS_LINE_ONE      2'h1
`define PPS_LINE_ZERO     2'h2
`define PPS_LINE_BAD      2'h0
`define PPS_SPD_S100      3'h0
`define PPS_SPD_S200      3'h1
`define PPS_SPD_S400      3'h2

// identification page, values arbitrary
`define PPS_COMPLIANCE    8'h01
`define PPS_VENDOR_ID     24'h5a_a5_01
`define PPS_PRODUCT_ID    24'h00_00_01

// timing
`define PPS_CLK_MHZ       250
`define PPS_CON_DEB_MS    341
`define PPS_BIAS_DEB_US   52
`define PPS_DEB_CW        27

// bus answers
`define PPS_RESP_OKAY     2'h0
`define PPS_RESP_SLVERR   2'h2
`define PPS_BYTE0         0

`endif

// [design/pps_sync3.v]
`timescale 1ns/1ps
`default_nettype none

module pps_sync3 #(
	parameter W = 1
) (
	input  wire         core_clk_i,
	input  wire         rst_n_i,
	input  wire [W-1:0] async_i,
	output reg  [W-1:0] sync_o
);

	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;

	// s1 feeds s2 only; a bit moves only once s2 and s3 agree
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			always @(posedge core_clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					s1_r[i]   <= 1'b0;
					s2_r[i]   <= 1'b0;
					s3_r[i]   <= 1'b0;
					sync_o[i] <= 1'b0;
				end
				else
				begin
					s1_r[i] <= async_i[i];
					s2_r[i] <= s1_r[i];
					s3_r[i] <= s2_r[i];
					if (s2_r[i] == s3_r[i])
						sync_o[i] <= s3_r[i];
				end
			end
		end
	endgenerate

endmodule // pps_sync3
`default_nettype wire

// [design/pps_debounce.v]
`timescale 1ns/1ps
`default_nettype none

`include "pps_consts.vh"

module pps_debounce #(
	parameter CYC = 1
) (
	input  wire core_clk_i,
	input  wire rst_n_i,
	input  wire level_i,
	output reg  stable_o
);

	localparam integer           LIM_I = CYC - 1;
	localparam [`PPS_DEB_CW-1:0] LIM   = LIM_I[`PPS_DEB_CW-1:0];

	reg [`PPS_DEB_CW-1:0] cnt_r;

	// rising side is filtered, a drop is reported at once
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_r    <= {`PPS_DEB_CW{1'b0}};
			stable_o <= 1'b0;
		end
		else if (!level_i)
		begin
			cnt_r    <= {`PPS_DEB_CW{1'b0}};
			stable_o <= 1'b0;
		end
		else if (cnt_r == LIM)
			stable_o <= 1'b1;
		else
			cnt_r <= cnt_r + {{(`PPS_DEB_CW-1){1'b0}}, 1'b1};
	end

endmodule // pps_debounce
`default_nettype wire

// [bench/pps_regs_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pps_consts.vh"

module pps_regs_asserts (
	input wire logic                     core_clk_i,
	input wire logic                     rst_n_i,
	input wire logic [31:0]              s_axi_awaddr,
	input wire logic                     s_axi_awvalid,
	input wire logic                     s_axi_awready,
	input wire logic [1:0]               s_axi_bresp,
	input wire logic                     s_axi_bvalid,
	input wire logic [31:0]              s_axi_araddr,
	input wire logic                     s_axi_arvalid,
	input wire logic                     s_axi_arready,
	input wire logic [31:0]              s_axi_rdata,
	input wire logic [1:0]               s_axi_rresp,
	input wire logic                     s_axi_rvalid,
	input wire logic                     s_axi_rready,
	input wire logic [`PPS_NPORTS-1:0]   resume_check_i,
	input wire logic [`PPS_NPORTS-1:0]   suspend_check_i,
	input wire logic [`PPS_NPORTS-1:0]   port_disable_o,
	input wire logic [`PPS_NPORTS-1:0]   port_hold_suspend_o,
	input wire logic                     link_notify_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_ar_far;
		s_ar_take ##0 s_axi_araddr[`PPS_A_HIGH] != `PPS_A_HIGH_ZERO;
	endsequence
	sequence s_aw_far;
		s_axi_awvalid && s_axi_awready && s_axi_awaddr[`PPS_A_HIGH] != `PPS_A_HIGH_ZERO;
	endsequence
	// the answer comes the cycle after the address is taken and holds until accepted
	property p_rd_lat; s_ar_take |=> s_axi_rvalid && !s_axi_arready; endproperty
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	property p_rd_high; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	property p_rd_far; s_ar_far |=> s_axi_rresp == `PPS_RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
	property p_wr_far; s_aw_far |-> ##[1:8] (s_axi_bvalid && s_axi_bresp == `PPS_RESP_SLVERR); endproperty
	// port off moves and notify drops only on a completed write; hold rises after a check, drops on a write
	property p_dis_wr; port_disable_o != $past(port_disable_o) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
	property p_hold_set;
		(port_hold_suspend_o & ~$past(port_hold_suspend_o)) != 0
			|-> ($past(resume_check_i) | $past(suspend_check_i)) != 0;
	endproperty
	property p_hold_clr;
		(~port_hold_suspend_o & $past(port_hold_suspend_o)) != 0 |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	property p_ntf_clr; $fell(link_notify_o) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	a_rd_hold: assert property (p_rd_hold) else $error("read answer moved");
	a_rd_high: assert property (p_rd_high) else $error("upper read bits set");
	a_rd_far: assert property (p_rd_far) else $error("unmapped read answer");
	a_wr_far: assert property (p_wr_far) else $error("unmapped write answer");
	a_dis_wr: assert property (p_dis_wr) else $error("port off moved alone");
	a_hold_set: assert property (p_hold_set) else $error("hold without check");
	a_hold_clr: assert property (p_hold_clr) else $error("hold dropped alone");
	a_ntf_clr: assert property (p_ntf_clr) else $error("notify dropped alone");
endmodule // pps_regs_asserts

bind pps_regs pps_regs_asserts u_asserts (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.resume_check_i(resume_check_i), .suspend_check_i(suspend_check_i),
	.port_disable_o(port_disable_o), .port_hold_suspend_o(port_hold_suspend_o),
	.link_notify_o(link_notify_o));
`default_nettype wire

// [bench/pps_port_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pps_consts.vh"

module pps_port_model (
	input  wire logic                       core_clk_i,
	input  wire logic [`PPS_NPORTS-1:0]     hold_i,
	output wire logic [2*`PPS_NPORTS-1:0]   pair_a_o,
	output wire logic [2*`PPS_NPORTS-1:0]   pair_b_o,
	output wire logic [`PPS_NPORTS-1:0]     conn_o,
	output wire logic [`PPS_NPORTS-1:0]     bias_o,
	output wire logic [`PPS_NPORTS-1:0]     child_o,
	output wire logic [`PPS_NPORTS-1:0]     susp_o,
	output wire logic [`PPS_NPORTS-1:0]     res_o,
	output wire logic [`PPS_NPORTS-1:0]     sus_o,
	output wire logic [3*`PPS_NPORTS-1:0]   speed_o
);
	logic [`PPS_NPORTS-1:0] conn_r = '0;
	logic [`PPS_NPORTS-1:0] bias_r = '0;
	logic [`PPS_NPORTS-1:0] res_r  = '0;
	logic [`PPS_NPORTS-1:0] sus_r  = '0;
	genvar p;
	assign conn_o = conn_r;
	assign bias_o = bias_r;
	assign res_o  = res_r;
	assign sus_o  = sus_r;
	// a faulted port stays suspended until software clears the fault
	assign susp_o = hold_i;
	for (p = 0; p < `PPS_NPORTS; p++)
	begin : g_port
		// an open port floats both pairs; odd ports face children
		assign pair_a_o[2*p+1:2*p] = conn_r[p] ? `PPS_LINE_ONE : `PPS_LINE_Z;
		assign pair_b_o[2*p+1:2*p] = conn_r[p] ? `PPS_LINE_ZERO : `PPS_LINE_Z;
		assign speed_o[3*p+2:3*p]  = 3'(p % 4);
		assign child_o[p]          = (p % 2 == 1);
	end
	task automatic set_peer(input logic [7:0] c, input logic [7:0] b);
		begin
			conn_r <= c;
			bias_r <= b;
		end
	endtask
	// one-cycle window-end pulse; caller enters just after a clock edge
	task automatic pulse(input logic suspend, input int p);
		begin
			if (suspend)
				sus_r[p] <= 1'b1;
			else
				res_r[p] <= 1'b1;
			@(posedge core_clk_i);
			sus_r <= '0;
			res_r <= '0;
		end
	endtask
endmodule // pps_port_model
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pps_consts.vh"

module tb;
	localparam int          NP    = `PPS_NPORTS;
	localparam logic [31:0] A_EVT = {26'h0, `PPS_IDX_EVT, 2'h0};
	localparam logic [31:0] A_IDX = {26'h0, `PPS_IDX_BASE, 2'h0};
	localparam logic [31:0] A_R8  = {26'h0, `PPS_IDX_R8, 2'h0};
	localparam logic [31:0] A_R9  = {26'h0, `PPS_IDX_R9, 2'h0};
	localparam logic [1:0]  OK    = `PPS_RESP_OKAY;
	localparam logic [1:0]  ERR   = `PPS_RESP_SLVERR;
	localparam logic [3:0]  ON    = {`PPS_LINE_ONE, `PPS_LINE_ZERO};
	localparam logic [3:0]  OFF   = {`PPS_LINE_Z, `PPS_LINE_Z};
	logic            core_clk_i = 1'b0;
	logic            rst_n_i    = 1'b0;
	logic [31:0]     awaddr     = '0;
	logic [31:0]     wdata      = '0;
	logic [31:0]     araddr     = '0;
	logic            awvalid    = 1'b0;
	logic            wvalid     = 1'b0;
	logic            bready     = 1'b0;
	logic            arvalid    = 1'b0;
	logic            rready     = 1'b0;
	logic            awready, wready, bvalid, arready, rvalid, notify;
	logic [1:0]      bresp, rresp;
	logic [31:0]     rdata;
	logic [2*NP-1:0] pa, pb;
	logic [NP-1:0]   cn, bs, ch, su, rc, sc, dis, hold;
	logic [3*NP-1:0] sp;
	int              mismatches = 0;
	int              n_compared = 0;

	always #2 core_clk_i = ~core_clk_i;

	pps_regs #(.CON_DEB_CYC(24), .BIAS_DEB_CYC(16)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cable_pair_a_state_i(pa), .cable_pair_b_state_i(pb), .port_connect_raw_i(cn),
		.port_bias_raw_i(bs), .port_is_child_i(ch), .port_suspended_i(su), .peer_speed_i(sp),
		.resume_check_i(rc), .suspend_check_i(sc), .port_disable_o(dis),
		.port_hold_suspend_o(hold), .link_notify_o(notify));
	pps_port_model PM (.core_clk_i(core_clk_i), .hold_i(hold), .pair_a_o(pa), .pair_b_o(pb),
		.conn_o(cn), .bias_o(bs), .child_o(ch), .susp_o(su), .res_o(rc), .sus_o(sc), .speed_o(sp));

	task automatic test_done;
		begin
			$display("compared %0d mismatches %0d", n_compared, mismatches);
			if (mismatches == 0 && n_compared > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			n_compared++;
			if (got !== exp)
			begin
				mismatches++;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task automatic hang;
		begin
			mismatches++;
			test_done();
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		begin
			@(posedge core_clk_i);
			awaddr <= a;
			wdata <= {24'h0, d};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			for (n = 0; n < 100; n++)
			begin
				@(posedge core_clk_i);
				if (awready === 1'b1) awvalid <= 1'b0;
				if (wready === 1'b1) wvalid <= 1'b0;
				if (bvalid === 1'b1) break;
			end
			if (n == 100) hang();
			bready <= 1'b0;
			chk({30'h0, bresp}, {30'h0, er});
		end
	endtask
	// rready rises with the request and stays up until rvalid is seen
	task automatic rd(input logic [31:0] a, input logic [7:0] ed, input logic [1:0] er);
		int n;
		begin
			@(posedge core_clk_i);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			for (n = 0; n < 100; n++)
			begin
				@(posedge core_clk_i);
				if (arready === 1'b1) arvalid <= 1'b0;
				if (rvalid === 1'b1) break;
			end
			if (n == 100) hang();
			rready <= 1'b0;
			chk(rdata, {24'h0, ed});
			chk({30'h0, rresp}, {30'h0, er});
		end
	endtask

	initial
	begin
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rd(A_IDX, 8'h00, OK);
		rd(A_R8, {OFF, 4'b1000}, OK);
		rd(A_R9, 8'h00, OK);
		wr(A_IDX, 8'hff, OK);
		rd(A_IDX, 8'hef, OK);
		rd(A_R8, 8'h00, OK);
		wr(A_IDX, {`PPS_PAGE_ID, 5'h0}, OK);
		rd(A_R8, `PPS_COMPLIANCE, OK);
		wr(A_IDX, 8'h09, OK);
		rd(A_R8, 8'h00, OK);
		wr(A_IDX, 8'h02, OK);
		wr(A_R9, 8'h10, OK);
		PM.set_peer(8'h04, 8'h04);
		repeat (8) @(posedge core_clk_i);
		rd(A_R8, {ON, 4'b1000}, OK);
		repeat (40) @(posedge core_clk_i);
		rd(A_R8, {ON, 4'b0110}, OK);
		rd(A_R9, {`PPS_SPD_S400, 5'h10}, OK);
		rd(A_EVT, 8'h01, OK);
		chk({31'h0, notify}, 32'h1);
		wr(A_EVT, 8'h01, OK);
		rd(A_EVT, 8'h00, OK);
		wr(A_R8, 8'hff, OK);
		rd(A_R8, {ON, 4'b1111}, OK);
		chk({24'h0, dis}, 32'h04);
		rd(A_EVT, 8'h01, OK);
		wr(A_IDX, 8'h03, OK);
		rd(A_R8, {OFF, 4'b1000}, OK);
		rd(A_R9, 8'h60, OK);
		chk({24'h0, dis}, 32'h04);
		wr(A_IDX, 8'h02, OK);
		wr(A_R8, 8'h00, OK);
		rd(A_R8, {ON, 4'b0110}, OK);
		chk({24'h0, dis}, 32'h00);
		wr(A_EVT, 8'h01, OK);
		PM.pulse(1'b0, 2);
		rd(A_R9, 8'h50, OK);
		PM.pulse(1'b1, 2);
		rd(A_R9, 8'h58, OK);
		chk({24'h0, hold}, 32'h04);
		rd(A_R8, {ON, 4'b1110}, OK);
		wr(A_R9, 8'h10, OK);
		rd(A_R9, 8'h58, OK);
		wr(A_R9, 8'h18, OK);
		rd(A_R9, 8'h50, OK);
		rd(A_EVT, 8'h01, OK);
		PM.set_peer(8'h04, 8'h00);
		repeat (8) @(posedge core_clk_i);
		PM.pulse(1'b1, 2);
		rd(A_R9, 8'h50, OK);
		PM.pulse(1'b0, 2);
		rd(A_R9, 8'h58, OK);
		wr(A_R9, 8'h18, OK);
		wr(32'h40, 8'hff, ERR);
		rd(32'h40, 8'h00, ERR);
		rd(32'h0, 8'h00, ERR);
		test_done();
	end
endmodule // tb
`default_nettype wire
